// [verilog/boot_cfg_map.svh]
`ifndef BOOT_CFG_MAP_SVH
`define BOOT_CFG_MAP_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_STARTUP_CTRL 10'h000
`define OFS_STARTUP_EEADDR 10'h001
`define OFS_IDENT_REV 10'h002
`define OFS_IDENT_MID 10'h003
`define OFS_IDENT_LOW 10'h004
`define OFS_CONFIG_LOW 10'h005
// ----------------------------------------------------------------------
// Block ranges (first and last offset)
// ----------------------------------------------------------------------
`define RNG_STARTUP_LO 10'h000
`define RNG_STARTUP_HI 10'h001
`define RNG_IDENT_LO 10'h002
`define RNG_IDENT_HI 10'h005
`define RNG_SERIAL_LO 10'h006
`define RNG_SERIAL_HI 10'h007
`define RNG_PLL_LO 10'h008
`define RNG_PLL_HI 10'h02F
`define RNG_GPIO_LO 10'h030
`define RNG_GPIO_HI 10'h038
`define RNG_OUTPUT_LO 10'h039
`define RNG_OUTPUT_HI 10'h04A
`define RNG_ODSRC_LO 10'h063
`define RNG_ODSRC_HI 10'h078
`define RNG_IRQEN 10'h079
`define RNG_FACT_LO 10'h07A
`define RNG_FACT_HI 10'h07B
`define RNG_IRQST_LO 10'h200
`define RNG_IRQST_HI 10'h201
`define RNG_GPI 10'h20C
`define RNG_GSTAT_LO 10'h20D
`define RNG_GSTAT_HI 10'h212
// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define RETRY_MSB 7
`define RETRY_LSB 3
`define RETRY_RST 5'h01
`define BIT_STORE_SEL 1
`define BIT_EXT_DIS 0
`define BIT_LONG_OFS 7
`define REV_RST 4'h0
`define CRC_OFFSET 8'h84
`define OTP_SHORT_BYTES 8'h08
`define BOOT_LAST_REG 8'h83
`endif

// [verilog/boot_cfg_pkg.sv]
package boot_cfg_pkg;
  // Register block selected by an offset
  typedef enum logic [3:0] {
    blk_startup, blk_ident, blk_serial, blk_pll, blk_gpio, blk_output,
    blk_monitor, blk_irq_en, blk_factory, blk_irq_stat, blk_gpi,
    blk_global, blk_reserved
  } reg_block_t;
  // Boot sequencer states
  typedef enum logic [2:0] {
    st_por, st_otp, st_arb, st_read, st_done, st_fail
  } boot_state_t;
endpackage : boot_cfg_pkg

// [verilog/block_decode.sv]
`timescale 1ns/1ps
`include "boot_cfg_map.svh"
// Decodes a register offset into its block
module block_decode
  import boot_cfg_pkg::*;
(
  input wire logic [9:0] addr,
  output reg_block_t block
);
  // ----------------------------------------------------------------------
  // Range helper
  // ----------------------------------------------------------------------
  function automatic logic in_rng(input logic [9:0] a, input logic [9:0] lo,
                                  input logic [9:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction : in_rng

  // Gaps in the map fall through to reserved
  always_comb begin
    if (in_rng(addr, `RNG_STARTUP_LO, `RNG_STARTUP_HI)) block = blk_startup;
    else if (in_rng(addr, `RNG_IDENT_LO, `RNG_IDENT_HI)) block = blk_ident;
    else if (in_rng(addr, `RNG_SERIAL_LO, `RNG_SERIAL_HI)) block = blk_serial;
    else if (in_rng(addr, `RNG_PLL_LO, `RNG_PLL_HI)) block = blk_pll;
    else if (in_rng(addr, `RNG_GPIO_LO, `RNG_GPIO_HI)) block = blk_gpio;
    else if (in_rng(addr, `RNG_OUTPUT_LO, `RNG_OUTPUT_HI)) block = blk_output;
    else if (in_rng(addr, `RNG_ODSRC_LO, `RNG_ODSRC_HI)) block = blk_monitor;
    else if (addr == `RNG_IRQEN) block = blk_irq_en;
    else if (in_rng(addr, `RNG_FACT_LO, `RNG_FACT_HI)) block = blk_factory;
    else if (in_rng(addr, `RNG_IRQST_LO, `RNG_IRQST_HI)) block = blk_irq_stat;
    else if (addr == `RNG_GPI) block = blk_gpi;
    else if (in_rng(addr, `RNG_GSTAT_LO, `RNG_GSTAT_HI)) block = blk_global;
    else block = blk_reserved;
  end
endmodule : block_decode

// [verilog/startup_boot_config_regs.sv]
`timescale 1ns/1ps
`include "boot_cfg_map.svh"
module startup_boot_config_regs
  import boot_cfg_pkg::*;
#(
  parameter logic [7:0] FACTORY_STARTUP = 8'h0B, // Factory startup byte
  parameter logic [7:0] FACTORY_EEADDR = 8'h50, // Factory memory address byte
  parameter logic [15:0] PART_CODE_RST = 16'h1234, // Arbitrary value
  parameter logic [10:0] DASH_RST = 11'h000, // Factory dash code
  parameter int unsigned POR_CYCLES = 16 // Internal power-up sequence length
) (
  input wire logic clock,
  input wire logic rstn,
  // Host register port from the serial slave
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [9:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic host_busy,
  output reg_block_t host_block,
  // Internal store load
  output logic otp_req,
  output logic otp_short,
  input wire logic otp_done,
  // Serial memory master (bus side lives in the serial engine)
  output logic mem_req,
  output logic [6:0] mem_slave_addr,
  output logic mem_long_offset,
  output logic [7:0] mem_first_offset,
  output logic [7:0] mem_last_offset,
  input wire logic mem_grant,
  input wire logic mem_arb_lost,
  input wire logic mem_nack,
  input wire logic mem_byte_valid,
  input wire logic [7:0] mem_byte,
  input wire logic mem_read_done,
  // Boot result
  output logic boot_failure_flag,
  output logic boot_done
);
  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [4:0] boot_retry_count_ff; // Extra arbitration attempts
  logic internal_store_load_select_ff; // 1: only first bytes from store
  logic external_boot_disable_ff; // 1: skip external memory
  logic long_offset_addressing_ff; // Two offset bytes
  logic [6:0] boot_memory_slave_address_ff; // Memory slave address
  logic [3:0] silicon_revision_ff; // Revision nibble
  logic [15:0] part_code_ff; // Part code
  logic [10:0] dash_code_ff; // Configuration dash code
  boot_state_t state_ff; // Boot sequencer
  logic [4:0] tries_ff; // Retries used
  logic [7:0] crc_ff; // Running CRC of received bytes
  logic [7:0] rx_ofs_ff; // Offset of next received byte
  logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_ff; // Power-up delay
  logic fail_ff; // Sticky failure
  logic [7:0] rdata_q_ff; // Registered read data
  logic host_ok; // Host access allowed

  // ----------------------------------------------------------------------
  // CRC-8, polynomial x^8+x^2+x+1, one byte at a time
  // ----------------------------------------------------------------------
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
    end
    crc8 = r;
  endfunction : crc8

  // ----------------------------------------------------------------------
  // Block decode
  // ----------------------------------------------------------------------
  block_decode u_decode (
    .addr(host_addr),
    .block(host_block)
  );

  // Host accesses are refused for the whole boot
  assign host_ok = (state_ff == st_done) || (state_ff == st_fail);
  assign host_busy = !host_ok;

  // ----------------------------------------------------------------------
  // Boot sequencer
  // ----------------------------------------------------------------------
  // Power-up wait, internal load, then optional external load
  always_ff @(posedge clock) begin
    if (!rstn) begin
      state_ff <= st_por;
      por_cnt_ff <= '0;
      tries_ff <= '0;
    end else begin
      case (state_ff)
        st_por: begin
          // Wait for the power-up sequence after reset release
          if (por_cnt_ff == POR_CYCLES[$bits(por_cnt_ff)-1:0] - 1'b1) begin
            state_ff <= st_otp;
          end else begin
            por_cnt_ff <= por_cnt_ff + 1'b1;
          end
        end
        st_otp: begin
          // External boot only when bit zero is low
          if (otp_done) begin
            state_ff <= external_boot_disable_ff ? st_done : st_arb;
          end
        end
        st_arb: begin
          if (mem_grant) begin
            state_ff <= st_read;
          end else if (mem_arb_lost) begin
            // First try is not counted against the retry field
            if (tries_ff == boot_retry_count_ff) begin
              state_ff <= st_fail;
            end else begin
              tries_ff <= tries_ff + 1'b1;
            end
          end
        end
        st_read: begin
          if (mem_nack) begin
            state_ff <= st_fail;
          end else if (mem_read_done) begin
            state_ff <= (rx_ofs_ff > `CRC_OFFSET) ? st_done : st_fail;
          end
        end
        st_done: state_ff <= st_done;
        st_fail: state_ff <= st_fail;
        default: state_ff <= st_fail;
      endcase
    end
  end

  // CRC tracking and check on the final byte
  always_ff @(posedge clock) begin
    if (!rstn) begin
      crc_ff <= 8'h00;
      rx_ofs_ff <= 8'h00;
      fail_ff <= 1'b0;
    end else begin
      if (state_ff == st_read && mem_byte_valid) begin
        rx_ofs_ff <= rx_ofs_ff + 1'b1;
        if (rx_ofs_ff == `CRC_OFFSET) begin
          if (mem_byte != crc_ff) begin
            fail_ff <= 1'b1;
          end
        end else begin
          crc_ff <= crc8(crc_ff, mem_byte);
        end
      end
      if ((state_ff == st_read && mem_nack) ||
          (state_ff == st_arb && mem_arb_lost && tries_ff == boot_retry_count_ff)) begin
        fail_ff <= 1'b1;
      end
    end
  end

  // Requests to the internal store and serial engine
  assign otp_req = (state_ff == st_otp);
  assign otp_short = internal_store_load_select_ff;
  assign mem_req = (state_ff == st_arb) || (state_ff == st_read);
  assign mem_slave_addr = boot_memory_slave_address_ff;
  assign mem_long_offset = long_offset_addressing_ff;
  assign mem_first_offset = 8'h00;
  assign mem_last_offset = `CRC_OFFSET;
  assign boot_failure_flag = fail_ff || (state_ff == st_fail);
  assign boot_done = host_ok;

  // ----------------------------------------------------------------------
  // Register writes (host only; loaded bytes feed the CRC and are not stored)
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      boot_retry_count_ff <= `RETRY_RST;
      internal_store_load_select_ff <= FACTORY_STARTUP[`BIT_STORE_SEL];
      external_boot_disable_ff <= FACTORY_STARTUP[`BIT_EXT_DIS];
      long_offset_addressing_ff <= FACTORY_EEADDR[`BIT_LONG_OFS];
      boot_memory_slave_address_ff <= FACTORY_EEADDR[6:0];
      silicon_revision_ff <= `REV_RST;
      part_code_ff <= PART_CODE_RST;
      dash_code_ff <= DASH_RST;
    end else if (host_ok && host_wr) begin
      case (host_addr)
        `OFS_STARTUP_CTRL: begin
          boot_retry_count_ff <= host_wdata[`RETRY_MSB:`RETRY_LSB];
          internal_store_load_select_ff <= host_wdata[`BIT_STORE_SEL];
          external_boot_disable_ff <= host_wdata[`BIT_EXT_DIS];
        end
        `OFS_STARTUP_EEADDR: begin
          long_offset_addressing_ff <= host_wdata[`BIT_LONG_OFS];
          boot_memory_slave_address_ff <= host_wdata[6:0];
        end
        `OFS_IDENT_REV: begin
          silicon_revision_ff <= host_wdata[7:4];
          part_code_ff[15:12] <= host_wdata[3:0];
        end
        `OFS_IDENT_MID: part_code_ff[11:4] <= host_wdata;
        `OFS_IDENT_LOW: begin
          part_code_ff[3:0] <= host_wdata[7:4];
          dash_code_ff[10:7] <= host_wdata[3:0];
        end
        `OFS_CONFIG_LOW: dash_code_ff[6:0] <= host_wdata[6:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Read data, registered; reserved and other blocks read zero here
  // ----------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rdata_q_ff <= 8'h00;
    end else if (host_ok && host_rd) begin
      case (host_addr)
        `OFS_STARTUP_CTRL: rdata_q_ff <= {boot_retry_count_ff, 1'b0,
          internal_store_load_select_ff, external_boot_disable_ff};
        `OFS_STARTUP_EEADDR: rdata_q_ff <= {long_offset_addressing_ff,
          boot_memory_slave_address_ff};
        `OFS_IDENT_REV: rdata_q_ff <= {silicon_revision_ff, part_code_ff[15:12]};
        `OFS_IDENT_MID: rdata_q_ff <= part_code_ff[11:4];
        `OFS_IDENT_LOW: rdata_q_ff <= {part_code_ff[3:0], dash_code_ff[10:7]};
        `OFS_CONFIG_LOW: rdata_q_ff <= {1'b0, dash_code_ff[6:0]};
        default: rdata_q_ff <= 8'h00;
      endcase
    end
  end

  assign host_rdata = rdata_q_ff;
endmodule : startup_boot_config_regs

// [dv/boot_mem_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Internal store and serial memory engine stand-in
// ----------------------------------------------------------------------
module boot_mem_model (
  input wire logic clock,
  input wire logic otp_req,
  input wire logic mem_req,
  input wire logic [3:0] lose,
  input wire logic crc_bad,
  input wire logic [7:0] nack_at,
  output logic otp_done,
  output logic mem_grant,
  output logic mem_arb_lost,
  output logic mem_nack,
  output logic mem_byte_valid,
  output logic [7:0] mem_byte,
  output logic mem_read_done
);
  logic [7:0] crc; // Running check byte over offsets 00..83
  logic [7:0] b; // Byte being sent
  // CRC-8, polynomial 07, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction : crc8
  // Serves one request at a time; every reply is a one-cycle strobe
  initial begin
    {otp_done, mem_grant, mem_arb_lost, mem_nack, mem_byte_valid, mem_read_done} = '0;
    mem_byte = 8'hA5;
    forever begin
      @(posedge clock);
      mem_byte <= ~mem_byte; // Idle line is inverted on every cycle between requests
      if (otp_req === 1'b1) begin
        repeat (3) @(posedge clock);
        otp_done <= 1'b1;
        @(posedge clock);
        otp_done <= 1'b0;
      end else if (mem_req === 1'b1) begin
        crc = 8'h00;
        // Lose arbitration lose times, then grant
        for (int k = 0; k <= lose; k++) begin
          @(posedge clock);
          if (mem_req !== 1'b1) break;
          if (k == lose) mem_grant <= 1'b1;
          else mem_arb_lost <= 1'b1;
          @(posedge clock);
          {mem_grant, mem_arb_lost} <= 2'b00;
        end
        // Offsets 00..84, the last one being the check byte
        for (int i = 0; i <= 132; i++) begin
          @(posedge clock);
          if (mem_req !== 1'b1) break;
          b = (i == 132) ? crc ^ {7'h00, crc_bad} : 8'(i * 29 + 90);
          crc = crc8(crc, b);
          mem_byte <= b;
          mem_byte_valid <= (i != nack_at);
          mem_nack <= (i == nack_at);
          @(posedge clock);
          {mem_byte_valid, mem_nack} <= 2'b00;
          mem_byte <= ~b;
        end
        @(posedge clock);
        mem_read_done <= (mem_req === 1'b1);
        @(posedge clock);
        mem_read_done <= 1'b0;
      end
    end
  end
endmodule : boot_mem_model

// [dv/startup_boot_config_regs_chk.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Port-level checks of decode, boot lockout and failure reporting
// ----------------------------------------------------------------------
module startup_boot_config_regs_chk
  import boot_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic [9:0] host_addr,
  input wire logic [7:0] host_rdata,
  input wire logic host_busy,
  input wire reg_block_t host_block,
  input wire logic otp_req,
  input wire logic mem_req,
  input wire logic mem_nack,
  input wire logic [7:0] mem_first_offset,
  input wire logic [7:0] mem_last_offset,
  input wire logic boot_failure_flag,
  input wire logic boot_done
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  chk_startup_decode: assert property (host_addr <= 10'h001 |-> host_block == blk_startup)
    else $error("startup offset decoded to wrong block");
  chk_global_decode: assert property (host_addr inside {[10'h20D:10'h212]} |->
    host_block == blk_global) else $error("boot status offset decoded wrong");
  chk_busy_level: assert property (host_busy != boot_done)
    else $error("busy and done disagree");
  chk_busy_rdata: assert property (host_busy |=> $stable(host_rdata))
    else $error("read data moved during boot");
  chk_flag_sticky: assert property (boot_failure_flag |=> boot_failure_flag)
    else $error("failure flag cleared without reset");
  chk_nack_abort: assert property (mem_req && mem_nack |-> ##[1:4] boot_failure_flag)
    else $error("nack did not flag failure");
  chk_crc_window: assert property (mem_req |-> mem_first_offset == 8'h00 &&
    mem_last_offset == 8'h84) else $error("read window offsets wrong");
  chk_mem_lockout: assert property (mem_req |-> host_busy && !otp_req)
    else $error("memory read outside boot lockout");
endmodule : startup_boot_config_regs_chk
bind startup_boot_config_regs startup_boot_config_regs_chk chk_u (.clock, .rstn, .host_addr,
  .host_rdata, .host_busy, .host_block, .otp_req, .mem_req, .mem_nack, .mem_first_offset,
  .mem_last_offset, .boot_failure_flag, .boot_done);

// [dv/startup_boot_config_regs_tb.sv]
`timescale 1ns/1ps
module startup_boot_config_regs_tb;
  import boot_cfg_pkg::*;
  // ----------------------------------------------------------------------
  // Signals, tables and bench state
  // ----------------------------------------------------------------------
  logic clock, rstn, host_wr, host_rd, otp_done, mem_grant, mem_arb_lost, mem_nack;
  logic mem_byte_valid, mem_read_done, crc_bad, host_busy, otp_req, otp_short, mem_req;
  logic mem_long_offset, boot_failure_flag, boot_done;
  logic b_req, b_done, b_fail, b_seen; // Second part, external load disabled
  logic [9:0] host_addr;
  logic [7:0] host_wdata, host_rdata, mem_byte, nack_at, mem_first_offset, mem_last_offset;
  logic [6:0] mem_slave_addr;
  logic [3:0] lose; // Arbitration losses before grant
  reg_block_t host_block;
  logic [7:0] w [6];
  logic [7:0] q [$]; // Expected answers, oldest first
  logic rd_pend = 1'b0, done_q = 1'b0;
  int errors = 0, checked = 0, seed = 32'hC6E791C1;
  localparam logic [7:0] MASK [6] = '{8'hFB, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F};
  localparam logic [7:0] RSTV [6] = '{8'h0A, 8'hD3, 8'h01, 8'h23, 8'h45, 8'h69};
  localparam logic [3:0] TL [6] = '{4'h0, 4'h1, 4'h2, 4'h0, 4'h0, 4'h0};
  localparam logic [7:0] TN [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h40, 8'hFF};
  localparam logic [5:0] TC = 6'b001000, TF = 6'b011100;
  // Part code keeps its default, itself an arbitrary value
  startup_boot_config_regs #(.FACTORY_STARTUP(8'h12), .FACTORY_EEADDR(8'hD3),
    .DASH_RST(11'h2E9)) dut_u (.clock, .rstn,
    .host_wr, .host_rd, .host_addr, .host_wdata, .host_rdata, .host_busy, .host_block,
    .otp_req, .otp_short, .otp_done, .mem_req, .mem_slave_addr, .mem_long_offset,
    .mem_first_offset, .mem_last_offset, .mem_grant, .mem_arb_lost, .mem_nack,
    .mem_byte_valid, .mem_byte, .mem_read_done, .boot_failure_flag, .boot_done);
  boot_mem_model mdl_u (.clock, .otp_req, .mem_req, .lose, .crc_bad, .nack_at, .otp_done,
    .mem_grant, .mem_arb_lost, .mem_nack, .mem_byte_valid, .mem_byte, .mem_read_done);
  // Default factory byte has bit zero set, so this part must skip the memory load
  startup_boot_config_regs dut_b_u (.clock, .rstn, .host_wr, .host_rd, .host_addr,
    .host_wdata, .host_rdata(), .host_busy(), .host_block(), .otp_req(), .otp_short(),
    .otp_done, .mem_req(b_req), .mem_slave_addr(), .mem_long_offset(),
    .mem_first_offset(), .mem_last_offset(), .mem_grant, .mem_arb_lost, .mem_nack,
    .mem_byte_valid, .mem_byte, .mem_read_done, .boot_failure_flag(b_fail),
    .boot_done(b_done));
  // Remembers any memory request from the second part since reset
  always @(posedge clock) begin
    if (rstn !== 1'b1) b_seen <= 1'b0;
    else if (b_req === 1'b1) b_seen <= 1'b1;
  end
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One-cycle host strobe
  task automatic access(input logic wr, input logic [9:0] a, input logic [7:0] d);
    @(posedge clock);
    host_wr <= wr;
    host_rd <= !wr;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clock);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
  endtask : access
  // Reset, try a write that boot must refuse, wait for the verdict
  task automatic boot(input int t);
    @(posedge clock);
    rstn <= 1'b0;
    lose <= TL[t];
    crc_bad <= TC[t];
    nack_at <= TN[t];
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    q.push_back(8'h00);
    q.push_back({7'h00, TF[t]});
    access(1'b1, 10'h005, 8'h11);
    access(1'b0, 10'h005, 8'h00);
    for (int i = 0; i < 3000 && boot_done !== 1'b1; i++) @(posedge clock);
    if (boot_done !== 1'b1) errors++;
    @(negedge clock);
    check("ext_disabled", {5'h00, b_fail, b_seen, b_done}, 8'h01);
    $display("boot test %0d done", t);
  endtask : boot
  task automatic summarize();
    errors += q.size();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  // ----------------------------------------------------------------------
  // Result watcher, watchdog and main sequence
  // ----------------------------------------------------------------------
  always @(negedge clock) begin
    if (rd_pend && q.size() > 0) check("host_rdata", host_rdata, q.pop_front());
    if (boot_done === 1'b1 && done_q !== 1'b1 && q.size() > 0)
      check("boot_failure_flag", {7'h00, boot_failure_flag}, q.pop_front());
    rd_pend = (host_rd === 1'b1);
    done_q = boot_done;
  end
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    summarize();
  end
  initial begin
    {rstn, host_wr, host_rd, crc_bad, lose} = '0;
    {host_addr, host_wdata, nack_at} = '0;
    for (int t = 0; t < 6; t++) boot(t);
    for (int a = 0; a < 6; a++) begin
      q.push_back(RSTV[a]);
      access(1'b0, 10'(a), 8'h00);
    end
    check("store_sel", {7'h00, otp_short}, 8'h01);
    check("slave_addr", {1'b0, mem_slave_addr}, 8'h53);
    check("long_ofs", {7'h00, mem_long_offset}, 8'h01);
    for (int a = 0; a < 6; a++) begin
      w[a] = 8'($random(seed)) & MASK[a];
      access(1'b1, 10'(a), w[a]);
      q.push_back(w[a]);
      access(1'b0, 10'(a), 8'h00);
    end
    check("store_sel_wr", {7'h00, otp_short}, {7'h00, w[0][1]});
    check("slave_addr_wr", {1'b0, mem_slave_addr}, {1'b0, w[1][6:0]});
    check("long_ofs_wr", {7'h00, mem_long_offset}, {7'h00, w[1][7]});
    for (int k = 0; k < 2; k++) begin
      access(1'b1, k ? 10'h20D : 10'h100, 8'h5A);
      q.push_back(8'h00);
      access(1'b0, k ? 10'h20D : 10'h100, 8'h00);
      check("host_block", 8'(host_block), 8'(k ? blk_global : blk_reserved));
    end
    repeat (3) @(posedge clock);
    $display("register tests done");
    summarize();
  end
endmodule : startup_boot_config_regs_tb
